// ---- core/interrupt_vector_stack_unit.sv ----
// Operation
// - flag register: negative bit2, zero bit1, carry bit0
// - flags never saved or restored on interrupts
// - stack pointer bytes at 3E high, 3D low
// - byte push decrements pointer by one
// - address push decrements pointer by two
// - byte pop increments pointer by one
// - address pop increments pointer by two
// - sixteen sources plus reset, own vectors
// - take only with source and global enable
// - lowest vector address served first
// - reset vectors to zero, highest priority
// - external requests vector to 1 and 2
// - timer two match 3, wrap 4
// - timer one capture 5, match 6, 7
// - timer one wrap 8, timer zero 9
// - spi done A, uart receive B
// - uart empty C, transmit done D
// - adc E, nvm ready F, comparator 10
// - entry clears global enable, return sets it
// - entry clears the served pending flag
// - masked requests stay pending until served/cleared
`default_nettype none
`include "ivsu_regs.svh"
module interrupt_vector_stack_unit #(
  parameter int SP_BITS = 10,
  parameter int NSRC    = `NUM_SOURCES
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic [NSRC-1:0]     irq_event,
  input  wire logic [NSRC-1:0]     irq_enable,
  input  wire logic [NSRC-1:0]     irq_sw_clear,
  input  wire logic                irq_ack,
  input  wire logic                return_from_handler_op,
  input  wire logic                subroutine_return_op,
  input  wire logic                call_op,
  input  wire logic                push_byte_op,
  input  wire logic                pop_byte_op,
  input  wire logic                flag_update,
  input  wire logic                result_negative,
  input  wire logic                result_zero,
  input  wire logic                result_carry,
  input  wire logic [5:0]          io_addr,
  input  wire logic                io_wr,
  input  wire logic [7:0]          io_wdata,
  output logic [7:0]               io_rdata,
  output logic                     irq_take,
  output logic [4:0]               irq_vector,
  output logic [NSRC-1:0]          irq_pending,
  output logic [7:0]               flag_register,
  output logic [SP_BITS-1:0]       stack_pointer
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [NSRC-1:0]     pending_ff;
  logic [NSRC-1:0]     nxt_pending;
  logic [7:0]          flag_ff;
  logic [7:0]          nxt_flag;
  logic [4:0]          vector_ff;
  logic [4:0]          nxt_vector;
  ivsu_pkg::vec_state_t state_ff;
  ivsu_pkg::vec_state_t nxt_state;
  logic                pick_any;
  logic [3:0]          pick_idx;
  logic [NSRC-1:0]     eligible;
  logic                take;
  logic [NSRC-1:0]     served;
  ivsu_pkg::stack_op_t sp_op;
  logic                wr_low;
  logic                wr_high;
  logic [15:0]         sp_wide;

  ////////////////////////////////////////////////////////////////////////
  // source selection
  assign eligible = pending_ff & irq_enable
                  & {NSRC{flag_ff[`FLAG_I_BIT]}};

  priority_pick #(
    .N (NSRC)
  ) u_pick (
    .req (eligible),
    .any (pick_any),
    .idx (pick_idx)
  );

  // one entry per pending request, held off while a take completes
  assign take = pick_any && (state_ff == ivsu_pkg::vec_idle);

  // pending flags: event sets, sw clear or service clears, set wins
  always_comb begin
    served = '0;
    if (take) begin
      served[pick_idx] = 1'b1;
    end
    nxt_pending = (pending_ff & ~(served | irq_sw_clear))
                | irq_event;
  end

  // vector number: source index plus one, reset is vector zero
  // source bit to vector map, lowest bit has the highest priority:
  //   bit 0  ext_request_zero      -> 01
  //   bit 1  ext_request_one       -> 02
  //   bit 2  t2_match_vector       -> 03
  //   bit 3  t2_wrap_vector        -> 04
  //   bit 4  t1_capture_vector     -> 05
  //   bit 5  t1_match_a_vector     -> 06
  //   bit 6  t1_match_b_vector     -> 07
  //   bit 7  t1_wrap_vector        -> 08
  //   bit 8  t0_wrap_vector        -> 09
  //   bit 9  spi_done_vector       -> 0A
  //   bit 10 uart receive done     -> 0B
  //   bit 11 uart_tx_empty_vector  -> 0C
  //   bit 12 uart transmit done    -> 0D
  //   bit 13 adc conversion done   -> 0E
  //   bit 14 nvm_ready_vector      -> 0F
  //   bit 15 comparator_vector     -> 10
  // the map is the plus-one below, so sources must be wired in this order
  always_comb begin
    nxt_vector = vector_ff;
    nxt_state  = state_ff;
    case (state_ff)
      ivsu_pkg::vec_idle: begin
        if (take) begin
          nxt_vector = 5'(pick_idx) + 5'h01;
          nxt_state  = ivsu_pkg::vec_taken;
        end
      end
      ivsu_pkg::vec_taken: begin
        if (irq_ack) begin
          nxt_state = ivsu_pkg::vec_idle;
        end
      end
      default: nxt_state = ivsu_pkg::vec_idle;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // flag register; no save or restore around handlers
  always_comb begin
    nxt_flag = flag_ff;
    if (io_wr && io_addr == `FLAG_REG_ADDR) begin
      nxt_flag = io_wdata;
    end
    if (flag_update) begin
      nxt_flag[`FLAG_N_BIT] = result_negative;
      nxt_flag[`FLAG_Z_BIT] = result_zero;
      nxt_flag[`FLAG_C_BIT] = result_carry;
    end
    if (return_from_handler_op) begin
      nxt_flag[`FLAG_I_BIT] = 1'b1;
    end
    if (take) begin
      nxt_flag[`FLAG_I_BIT] = 1'b0;
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_ff <= '0;
      flag_ff    <= `FLAG_RESET;
      vector_ff  <= `RESET_VECTOR;
      state_ff   <= ivsu_pkg::vec_idle;
    end else begin
      pending_ff <= nxt_pending;
      flag_ff    <= nxt_flag;
      vector_ff  <= nxt_vector;
      state_ff   <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stack pointer, address push on call or interrupt entry
  always_comb begin
    sp_op = ivsu_pkg::stack_none;
    if (take || call_op) begin
      sp_op = ivsu_pkg::stack_push_addr;
    end else if (return_from_handler_op || subroutine_return_op) begin
      sp_op = ivsu_pkg::stack_pop_addr;
    end else if (push_byte_op) begin
      sp_op = ivsu_pkg::stack_push_byte;
    end else if (pop_byte_op) begin
      sp_op = ivsu_pkg::stack_pop_byte;
    end
  end

  assign wr_low  = io_wr && io_addr == `SP_LOW_ADDR;
  assign wr_high = io_wr && io_addr == `SP_HIGH_ADDR;

  stack_pointer_unit #(
    .SP_BITS (SP_BITS)
  ) u_sp (
    .clk     (clk),
    .rst_b   (rst_b),
    .op      (sp_op),
    .wr_low  (wr_low),
    .wr_high (wr_high),
    .wdata   (io_wdata),
    .sp      (stack_pointer)
  );

  // read mux; unused upper pointer bits read zero
  always_comb begin
    sp_wide = 16'(stack_pointer);
    case (io_addr)
      `SP_LOW_ADDR:   io_rdata = sp_wide[7:0];
      `SP_HIGH_ADDR:  io_rdata = sp_wide[15:8];
      `FLAG_REG_ADDR: io_rdata = flag_ff;
      default:        io_rdata = 8'h00;
    endcase
  end

  assign irq_take      = take;
  assign irq_vector    = vector_ff;
  assign irq_pending   = pending_ff;
  assign flag_register = flag_ff;
endmodule // interrupt_vector_stack_unit
`default_nettype wire

// ---- core/ivsu_regs.svh ----
`ifndef IVSU_REGS_SVH
`define IVSU_REGS_SVH
// i/o offsets of the stack pointer bytes and the flag register
`define SP_LOW_ADDR    6'h3D
`define SP_HIGH_ADDR   6'h3E
`define FLAG_REG_ADDR  6'h3F
// flag register bit positions
`define FLAG_C_BIT     0
`define FLAG_Z_BIT     1
`define FLAG_N_BIT     2
`define FLAG_I_BIT     7
// reset values
`define SP_RESET       10'h000
`define FLAG_RESET     8'h00
// vector table
`define RESET_VECTOR   5'h00
`define NUM_SOURCES    16
`endif

// ---- core/ivsu_pkg.sv ----
`default_nettype none
package ivsu_pkg;
  // stack pointer operation requested by the sequencer
  typedef enum logic [2:0] {
    stack_none,
    stack_push_byte,
    stack_push_addr,
    stack_pop_byte,
    stack_pop_addr
  } stack_op_t;
  // vector sequencing state
  typedef enum logic [1:0] {
    vec_idle,
    vec_taken
  } vec_state_t;
endpackage
`default_nettype wire

// ---- core/priority_pick.sv ----
`default_nettype none
module priority_pick #(
  parameter int N = 16
) (
  input  wire logic [N-1:0]         req,
  output logic                      any,
  output logic [$clog2(N)-1:0]      idx
);
  // lowest index wins, so scan downward
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[$clog2(N)-1:0];
      end
    end
  end
endmodule // priority_pick
`default_nettype wire

// ---- core/stack_pointer_unit.sv ----
`default_nettype none
`include "ivsu_regs.svh"
module stack_pointer_unit #(
  parameter int SP_BITS = 10
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire ivsu_pkg::stack_op_t op,
  input  wire logic               wr_low,
  input  wire logic               wr_high,
  input  wire logic [7:0]         wdata,
  output logic [SP_BITS-1:0]      sp
);
  logic [SP_BITS-1:0] stack_pointer_ff;
  logic [SP_BITS-1:0] nxt_stack_pointer;
  logic [15:0]        wide;

  // software writes take the byte, stack ops step the pointer
  always_comb begin
    wide = 16'(stack_pointer_ff);
    if (wr_low) begin
      wide[7:0] = wdata;
    end
    if (wr_high) begin
      wide[15:8] = wdata;
    end
    nxt_stack_pointer = wide[SP_BITS-1:0];
    case (op)
      ivsu_pkg::stack_push_byte: nxt_stack_pointer =
        stack_pointer_ff - SP_BITS'(1);
      ivsu_pkg::stack_push_addr: nxt_stack_pointer =
        stack_pointer_ff - SP_BITS'(2);
      ivsu_pkg::stack_pop_byte: nxt_stack_pointer =
        stack_pointer_ff + SP_BITS'(1);
      ivsu_pkg::stack_pop_addr: nxt_stack_pointer =
        stack_pointer_ff + SP_BITS'(2);
      default: ;
    endcase
  end

  // pointer register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_pointer_ff <= SP_BITS'(`SP_RESET);
    end else begin
      stack_pointer_ff <= nxt_stack_pointer;
    end
  end

  assign sp = stack_pointer_ff;
endmodule // stack_pointer_unit
`default_nettype wire

// ---- tb/ivsu_seq.sv ----
`default_nettype none
module ivsu_seq #(
  parameter int LAT = 3
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic take,
  output logic      ack
);
  int cnt;
  // acknowledge a taken vector a fixed number of cycles later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      ack <= 1'b0;
    end else begin
      ack <= (cnt == 1);
      if (take) cnt <= LAT;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule // ivsu_seq
`default_nettype wire

// ---- tb/ivsu_chk.sv ----
`default_nettype none
module ivsu_chk #(
  parameter int SP_BITS = 10,
  parameter int NSRC    = 16
) (
  input wire logic clk, rst_b, irq_take, call_op,
  input wire logic push_byte_op, pop_byte_op, flag_update,
  input wire logic return_from_handler_op, subroutine_return_op,
  input wire logic result_negative, result_zero, result_carry,
  input wire logic [NSRC-1:0] irq_pending, irq_enable,
  input wire logic [4:0] irq_vector,
  input wire logic [7:0] flag_register,
  input wire logic [SP_BITS-1:0] stack_pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // two-byte moves outrank byte moves
  wire t2 = call_op | irq_take;
  wire r2 = return_from_handler_op | subroutine_return_op;
  wire [SP_BITS-1:0] sp = stack_pointer;
  a_push_one: assert property (
    push_byte_op && !t2 && !r2 |=> sp == SP_BITS'($past(sp) - 1)
  ) else $error("byte push step");
  a_pop_one: assert property (
    pop_byte_op && !push_byte_op && !t2 && !r2 |=>
      sp == SP_BITS'($past(sp) + 1)
  ) else $error("byte pop step");
  a_push_two: assert property (
    t2 |=> sp == SP_BITS'($past(sp) - 2)
  ) else $error("address push step");
  a_pop_two: assert property (
    r2 && !t2 |=> sp == SP_BITS'($past(sp) + 2)
  ) else $error("address pop step");
  a_take_gated: assert property (
    irq_take |-> flag_register[7] && |(irq_pending & irq_enable)
  ) else $error("take without enables");
  a_entry_clr: assert property (
    irq_take |=> !flag_register[7]
  ) else $error("global enable kept");
  a_return_set: assert property (
    return_from_handler_op && !irq_take |=> flag_register[7]
  ) else $error("global enable not set");
  a_first_wins: assert property (
    irq_take && irq_pending[0] && irq_enable[0] |=> irq_vector == 5'h01
  ) else $error("priority lost");
  a_flags_load: assert property (
    flag_update |=> flag_register[2:0] == {$past(result_negative),
      $past(result_zero), $past(result_carry)}
  ) else $error("result flags");
endmodule // ivsu_chk
bind interrupt_vector_stack_unit ivsu_chk #(.SP_BITS(SP_BITS), .NSRC(NSRC))
  u_chk (.clk, .rst_b, .irq_take, .call_op, .push_byte_op, .pop_byte_op,
  .flag_update, .return_from_handler_op, .subroutine_return_op,
  .result_negative, .result_zero, .result_carry, .irq_pending, .irq_enable,
  .irq_vector, .flag_register, .stack_pointer);
`default_nettype wire

// ---- tb/test_interrupt_vector_stack_unit.sv ----
`default_nettype none
module test_interrupt_vector_stack_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, irq_ack, irq_take, io_wr = 0;
  logic call_op = 0, push_byte_op = 0, pop_byte_op = 0, flag_update = 0;
  logic return_from_handler_op = 0, subroutine_return_op = 0;
  logic result_negative = 1, result_zero = 0, result_carry = 1;
  logic [15:0] irq_event = 0, irq_enable = 0, irq_sw_clear = 0, irq_pending;
  logic [5:0] io_addr = 0;
  logic [7:0] io_wdata = 0, io_rdata, flag_register;
  logic [4:0] irq_vector;
  logic [9:0] stack_pointer;
  int n_mismatch = 0, compares = 0;
  // expected vector per source row
  logic [4:0] vt [16] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10};
  interrupt_vector_stack_unit dut (.clk, .rst_b, .irq_event, .irq_enable,
    .irq_sw_clear, .irq_ack, .return_from_handler_op, .subroutine_return_op,
    .call_op, .push_byte_op, .pop_byte_op, .flag_update, .result_negative,
    .result_zero, .result_carry, .io_addr, .io_wr, .io_wdata, .io_rdata,
    .irq_take, .irq_vector, .irq_pending, .flag_register, .stack_pointer);
  ivsu_seq #(.LAT(3)) seq (.clk, .rst_b, .take(irq_take), .ack(irq_ack));
  initial forever #25 clk = ~clk;
  task automatic chk(logic [15:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %h, expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(logic [5:0] ad, logic [7:0] dv);
    io_addr = ad;
    io_wdata = dv;
    io_wr = 1;
    @(negedge clk) io_wr = 0;
  endtask
  task automatic rc(logic [5:0] ad, logic [7:0] e);
    io_addr = ad;
    #1 chk(io_rdata, e);
  endtask
  task automatic pl(ref logic s);
    s = 1;
    @(negedge clk) s = 0;
  endtask
  task automatic wt;
    for (int k = 0; k < 20 && irq_take !== 1; k++) @(negedge clk);
    if (irq_take !== 1) begin
      n_mismatch++;
      end_of_test;
    end
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1;
    rc(6'h3D, 8'h00);
    rc(6'h3E, 8'h00);
    wr(6'h3E, 8'hFF);
    rc(6'h3E, 8'h03);
    wr(6'h3E, 8'h02);
    wr(6'h3D, 8'h00);
    chk(stack_pointer, 16'h0200);
    pl(push_byte_op);
    chk(stack_pointer, 16'h01FF);
    pl(pop_byte_op);
    chk(stack_pointer, 16'h0200);
    pl(call_op);
    chk(stack_pointer, 16'h01FE);
    pl(subroutine_return_op);
    chk(stack_pointer, 16'h0200);
    pl(flag_update);
    chk(flag_register, 16'h0005);
    // one source at a time through entry and return
    for (int i = 0; i < 16; i++) begin
      irq_enable = 16'h0001 << i;
      wr(6'h3F, 8'h82);
      irq_event = irq_enable;
      @(negedge clk) irq_event = 0;
      wt;
      @(negedge clk);
      chk(irq_vector, vt[i]);
      chk(irq_pending, 16'h0000);
      chk(flag_register, 16'h0002);
      chk(stack_pointer, 16'h01FE);
      repeat (3) @(negedge clk);
      pl(return_from_handler_op);
      chk(flag_register, 16'h0082);
      chk(stack_pointer, 16'h0200);
    end
    // two held requests, then global enable
    wr(6'h3F, 8'h00);
    irq_enable = 16'hFFFF;
    irq_event = 16'h0204;
    @(negedge clk) irq_event = 0;
    repeat (2) @(negedge clk);
    chk(irq_take, 16'h0000);
    chk(irq_pending, 16'h0204);
    wr(6'h3F, 8'h80);
    wt;
    @(negedge clk);
    chk(irq_vector, 16'h0003);
    chk(irq_pending, 16'h0200);
    irq_sw_clear = 16'h0200;
    @(negedge clk) irq_sw_clear = 0;
    chk(irq_pending, 16'h0000);
    // reset in mid-run
    rst_b = 0;
    #1 chk(stack_pointer, 16'h0000);
    chk(irq_vector, 16'h0000);
    chk(irq_pending, 16'h0000);
    chk(flag_register, 16'h0000);
    @(negedge clk) rst_b = 1;
    end_of_test;
  end
endmodule // test_interrupt_vector_stack_unit
`default_nettype wire
